// file: pkg/jarf_pkg.sv
package jarf_pkg;
    // parameter group numbers and priorities
    localparam logic [17:0] PGN_SLOPE = 18'h0F029;
    localparam logic [17:0] PGN_RATE = 18'h0F02A;
    localparam logic [17:0] PGN_DIRSPD = 18'h0FEE8;
    localparam logic [17:0] PGN_DIRSPD2 = 18'h0FD89;
    localparam logic [2:0] PRIO_PERIODIC = 3'h3;
    localparam logic [2:0] PRIO_ON_REQUEST = 3'h6;
    // payload layout, byte 1 sits in bits 7:0
    localparam int PAYLOAD_BITS = 64;
    localparam int POS_B12 = 0;
    localparam int POS_B34 = 16;
    localparam int POS_B56 = 32;
    localparam int POS_B78 = 48;
    localparam int POS_SLOPE_ROLL = 24;
    localparam int POS_B7 = 48;
    localparam int POS_B8 = 56;
    // scaling offsets, limits and fill values in raw counts
    localparam logic [15:0] RATE_OFFSET = 16'h7D00;
    localparam logic [15:0] ANGLE128_OFFSET = 16'h6400;
    localparam logic [23:0] ANGLE32K_OFFSET = 24'h7D0000;
    localparam logic [15:0] RAW16_MAX = 16'hFAFF;
    localparam logic [23:0] RAW24_MAX = 24'hFAFFFF;
    localparam logic [15:0] ROLL_LIMIT = 16'h2D00;
    localparam logic [7:0] LATENCY_MAX = 8'hFA;
    localparam logic [15:0] FILL16 = 16'hFFFF;
    localparam logic [1:0] FILL2 = 2'h3;
    // two-bit status codes
    localparam logic [1:0] COMP_ON = 2'h0;
    localparam logic [1:0] COMP_OFF = 2'h1;
    localparam logic [1:0] CODE_ERROR = 2'h2;
    localparam logic [1:0] CODE_NA = 2'h3;
    // repetition timing
    localparam int FRAME_PERIOD_MS = 10;
    localparam int CLK_HZ = 10000000;
    localparam int PERIOD_CYC = CLK_HZ / 1000 * FRAME_PERIOD_MS;
    // frame word carried through the buffer
    localparam int FRAME_BITS = 18 + 3 + PAYLOAD_BITS;
    typedef enum logic [2:0] {MSG_NONE, MSG_SLOPE, MSG_RATE, MSG_DIRSPD, MSG_DIRSPD2} jarf_msg_t;
endpackage

// file: design/jarf_two_entry_buf.sv
`timescale 1ns/1ps
module jarf_two_entry_buf #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] slot_q [2];
    logic [WIDTH-1:0] slot_d [2];
    logic wrIdx_q, wrIdx_d, rdIdx_q, rdIdx_d;
    logic [1:0] count_q, count_d;
    logic push, pop;

    // handshakes from fill level
    assign inReady = (count_q != 2'h2);
    assign outValid = (count_q != 2'h0);
    assign outData = slot_q[rdIdx_q];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // next slot contents and pointers
    always_comb
    begin
        slot_d = slot_q;
        wrIdx_d = wrIdx_q;
        rdIdx_d = rdIdx_q;
        count_d = count_q;
        if (push)
        begin
            slot_d[wrIdx_q] = inData;
            wrIdx_d = ~wrIdx_q;
        end
        if (pop)
            rdIdx_d = ~rdIdx_q;
        if (push && !pop)
            count_d = count_q + 2'h1;
        else if (pop && !push)
            count_d = count_q - 2'h1;
    end

    // register state
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slot_q[0] <= '0;
            slot_q[1] <= '0;
            wrIdx_q <= 1'b0;
            rdIdx_q <= 1'b0;
            count_q <= 2'h0;
        end
        else
        begin
            slot_q <= slot_d;
            wrIdx_q <= wrIdx_d;
            rdIdx_q <= rdIdx_d;
            count_q <= count_d;
        end
    end
endmodule // jarf_two_entry_buf

// file: design/jarf_framer.sv
`timescale 1ns/1ps
module jarf_framer #(
    parameter int PERIOD_CYC = jarf_pkg::PERIOD_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic slopeEnable,
    input wire logic rateEnable,
    input wire logic reqValid,
    input wire logic [17:0] reqPgn,
    input wire logic signed [23:0] pitchAngle,
    input wire logic signed [23:0] rollAngle,
    input wire logic compOn,
    input wire logic pitchCompErr,
    input wire logic rollCompErr,
    input wire logic [1:0] pitchQual,
    input wire logic [1:0] rollQual,
    input wire logic [7:0] angleLatency,
    input wire logic signed [15:0] pitchRate,
    input wire logic signed [15:0] rollRate,
    input wire logic signed [15:0] yawRate,
    input wire logic [1:0] pitchRateQual,
    input wire logic [1:0] rollRateQual,
    input wire logic [1:0] yawRateQual,
    input wire logic [7:0] rateLatency,
    input wire logic signed [15:0] vehPitch,
    input wire logic signed [15:0] vehRoll,
    output logic txValid,
    input wire logic txReady,
    output logic [17:0] txPgn,
    output logic [2:0] txPrio,
    output logic [63:0] txData
);
    import jarf_pkg::*;

    localparam int TW = $clog2(PERIOD_CYC + 1);
    localparam logic [TW-1:0] TICK_AT = TW'(PERIOD_CYC - 1);

    logic [TW-1:0] timer_q, timer_d;
    logic pendSlope_q, pendSlope_d, pendRate_q, pendRate_d;
    logic pendDs_q, pendDs_d, pendDs2_q, pendDs2_d;
    logic tick, reqDs, reqDs2, pushReady, fire;
    jarf_msg_t sel;
    logic [17:0] pushPgn;
    logic [2:0] pushPrio;
    logic [63:0] pushData;
    logic [FRAME_BITS-1:0] outWord;

    // offset, then clamp into the valid 16-bit raw range
    function automatic logic [15:0] enc16(input logic signed [15:0] v, input logic [15:0] ofs);
        logic signed [17:0] s;
        s = 18'(v) + $signed({2'b00, ofs});
        if (s < 0)
            enc16 = 16'h0000;
        else if (s > $signed({2'b00, RAW16_MAX}))
            enc16 = RAW16_MAX;
        else
            enc16 = s[15:0];
    endfunction

    // 24-bit angle at 1/32768 deg with offset, clamped
    function automatic logic [23:0] enc24(input logic signed [23:0] v);
        logic signed [25:0] s;
        s = 26'(v) + $signed({2'b00, ANGLE32K_OFFSET});
        if (s < 0)
            enc24 = 24'h000000;
        else if (s > $signed({2'b00, RAW24_MAX}))
            enc24 = RAW24_MAX;
        else
            enc24 = s[23:0];
    endfunction

    // compensation state code
    function automatic logic [1:0] compCode(input logic on, input logic err);
        compCode = err ? CODE_ERROR : (on ? COMP_ON : COMP_OFF);
    endfunction

    // latency count limited to 125 ms
    function automatic logic [7:0] latLimit(input logic [7:0] c);
        latLimit = (c > LATENCY_MAX) ? LATENCY_MAX : c;
    endfunction

    // roll limited to +-90 deg before encoding
    function automatic logic signed [15:0] rollLimit(input logic signed [15:0] v);
        if (v > $signed(ROLL_LIMIT))
            rollLimit = $signed(ROLL_LIMIT);
        else if (v < -$signed(ROLL_LIMIT))
            rollLimit = -$signed(ROLL_LIMIT);
        else
            rollLimit = v;
    endfunction

    // request decode and period tick
    assign tick = (timer_q == TICK_AT);
    assign reqDs = reqValid && (reqPgn == PGN_DIRSPD);
    assign reqDs2 = reqValid && (reqPgn == PGN_DIRSPD2);
    assign fire = (sel != MSG_NONE) && pushReady;

    // fixed priority among pending frames
    always_comb
    begin
        if (pendSlope_q)
            sel = MSG_SLOPE;
        else if (pendRate_q)
            sel = MSG_RATE;
        else if (pendDs_q)
            sel = MSG_DIRSPD;
        else if (pendDs2_q)
            sel = MSG_DIRSPD2;
        else
            sel = MSG_NONE;
    end

    // frame assembly for the selected message
    always_comb
    begin
        pushPgn = PGN_SLOPE;
        pushPrio = PRIO_PERIODIC;
        pushData = '1;
        case (sel)
            MSG_SLOPE:
            begin
                pushPgn = PGN_SLOPE;
                pushPrio = PRIO_PERIODIC;
                pushData[POS_B12 +: 24] = enc24(pitchAngle);
                pushData[POS_SLOPE_ROLL +: 24] = enc24(rollAngle);
                pushData[POS_B7 +: 8] = {rollQual, compCode(compOn, rollCompErr),
                    pitchQual, compCode(compOn, pitchCompErr)};
                pushData[POS_B8 +: 8] = latLimit(angleLatency);
            end
            MSG_RATE:
            begin
                pushPgn = PGN_RATE;
                pushPrio = PRIO_PERIODIC;
                pushData[POS_B12 +: 16] = enc16(pitchRate, RATE_OFFSET);
                pushData[POS_B34 +: 16] = enc16(rollRate, RATE_OFFSET);
                pushData[POS_B56 +: 16] = enc16(yawRate, RATE_OFFSET);
                pushData[POS_B7 +: 8] = {FILL2, yawRateQual, rollRateQual, pitchRateQual};
                pushData[POS_B8 +: 8] = rateLatency;
            end
            MSG_DIRSPD:
            begin
                pushPgn = PGN_DIRSPD;
                pushPrio = PRIO_ON_REQUEST;
                pushData[POS_B12 +: 16] = FILL16;
                pushData[POS_B34 +: 16] = FILL16;
                pushData[POS_B56 +: 16] = enc16(vehPitch, ANGLE128_OFFSET);
                pushData[POS_B78 +: 16] = FILL16;
            end
            MSG_DIRSPD2:
            begin
                pushPgn = PGN_DIRSPD2;
                pushPrio = PRIO_ON_REQUEST;
                pushData[POS_B12 +: 16] = enc16(rollLimit(vehRoll), ANGLE128_OFFSET);
            end
            default:
            begin
                pushPgn = PGN_SLOPE;
                pushPrio = PRIO_PERIODIC;
            end
        endcase
    end

    // next timer and pending flags; a set in the clearing cycle wins
    always_comb
    begin
        timer_d = tick ? '0 : timer_q + TW'(1);
        pendSlope_d = ((pendSlope_q && !(fire && sel == MSG_SLOPE)) || tick) && slopeEnable;
        pendRate_d = ((pendRate_q && !(fire && sel == MSG_RATE)) || tick) && rateEnable;
        pendDs_d = (pendDs_q && !(fire && sel == MSG_DIRSPD)) || reqDs;
        pendDs2_d = (pendDs2_q && !(fire && sel == MSG_DIRSPD2)) || reqDs2;
    end

    // register timer and flags
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timer_q <= '0;
            pendSlope_q <= 1'b0;
            pendRate_q <= 1'b0;
            pendDs_q <= 1'b0;
            pendDs2_q <= 1'b0;
        end
        else
        begin
            timer_q <= timer_d;
            pendSlope_q <= pendSlope_d;
            pendRate_q <= pendRate_d;
            pendDs_q <= pendDs_d;
            pendDs2_q <= pendDs2_d;
        end
    end

    // buffer between framer and transmit path, absorbs stalls
    jarf_two_entry_buf #(
        .WIDTH(FRAME_BITS)
    ) u_buf (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .inValid(sel != MSG_NONE),
        .inReady(pushReady),
        .inData({pushPgn, pushPrio, pushData}),
        .outValid(txValid),
        .outReady(txReady),
        .outData(outWord)
    );

    // split the buffered word onto the frame ports
    assign txPgn = outWord[FRAME_BITS-1 -: 18];
    assign txPrio = outWord[PAYLOAD_BITS +: 3];
    assign txData = outWord[PAYLOAD_BITS-1:0];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // rate frame pending one cycle after an enabled tick
    AST_RATE_PERIOD: assert property (tick && rateEnable |=> pendRate_q)
        else $error("rate frame not scheduled on tick");

    // rate frame header and filler bits
    AST_RATE_HEADER: assert property (fire && sel == MSG_RATE |->
        pushPgn == 18'h0F02A && pushPrio == 3'h3 && pushData[63-8 -: 2] == 2'h3)
        else $error("rate frame header or filler wrong");

    // decoding pitch rate count gives back the input when in range
    AST_RATE_SCALE: assert property (fire && sel == MSG_RATE && pitchRate > -16'sd32000
        && pitchRate < 16'sd32000 |-> $signed(pushData[15:0] - 16'h7D00) == pitchRate)
        else $error("rate scaling wrong");

    // yaw in bytes 5-6 and quality codes in byte 7
    AST_RATE_FIELDS: assert property (fire && sel == MSG_RATE && yawRate == 16'sh0000 |->
        pushData[47:32] == 16'h7D00 && pushData[53:48] == {yawRateQual, rollRateQual,
        pitchRateQual})
        else $error("rate fields misplaced");

    // rate latency passes through untouched
    AST_RATE_LAT: assert property (fire && sel == MSG_RATE |-> pushData[63:56] == rateLatency)
        else $error("rate latency wrong");

    // roll compensation code tracks the compensation inputs
    AST_SLOPE_COMP: assert property (fire && sel == MSG_SLOPE && !rollCompErr |->
        pushData[53:52] == (compOn ? 2'h0 : 2'h1))
        else $error("roll compensation code wrong");

    // roll quality at byte 7 bit 7
    AST_SLOPE_QUAL: assert property (fire && sel == MSG_SLOPE |-> pushData[55:54] == rollQual)
        else $error("roll quality misplaced");

    // slope latency never above 125 ms
    AST_SLOPE_LAT: assert property (fire && sel == MSG_SLOPE |-> pushData[63:56] <= 8'hFA)
        else $error("slope latency out of range");

    // slope frame header and zero-angle encoding
    AST_SLOPE_HDR: assert property (fire && sel == MSG_SLOPE && pitchAngle == 24'sh0 |->
        pushPgn == 18'h0F029 && pushData[23:0] == 24'h7D0000)
        else $error("slope header or pitch wrong");

    // direction/speed only becomes pending after a request
    AST_DS_ONREQ: assert property ($rose(pendDs_q) |-> $past(reqValid) &&
        $past(reqPgn) == 18'h0FEE8)
        else $error("direction/speed pending without request");

    // unused direction/speed fields are all ones
    AST_DS_FILL: assert property (fire && sel == MSG_DIRSPD |-> pushPrio == 3'h6 &&
        pushData[31:0] == 32'hFFFFFFFF && pushData[63:48] == 16'hFFFF)
        else $error("direction/speed filler wrong");

    // zero pitch encodes to the offset count
    AST_DS_PITCH: assert property (fire && sel == MSG_DIRSPD && vehPitch == 16'sh0 |->
        pushData[47:32] == 16'h6400)
        else $error("direction/speed pitch wrong");

    // second frame only after its request, roll held within +-90 deg
    AST_DS2_ONREQ: assert property ($rose(pendDs2_q) |-> $past(reqValid) &&
        $past(reqPgn) == 18'h0FD89)
        else $error("second frame pending without request");
    AST_DS2_ROLL: assert property (fire && sel == MSG_DIRSPD2 |->
        pushData[15:0] >= 16'h3700 && pushData[15:0] <= 16'h9100
        && pushData[63:16] == 48'hFFFFFFFFFFFF)
        else $error("second frame roll out of range");

    // a stalled receiver never loses a buffered frame
    AST_TX_HOLD: assert property (txValid && !txReady |=> txValid && $stable(txData)
        && $stable(txPgn) && $stable(txPrio))
        else $error("frame dropped under stall");
endmodule // jarf_framer

// file: sim/jarf_tx_sink.sv
`timescale 1ns/1ps
// downstream transmit path model: takes frames, stalls on command
module jarf_tx_sink (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic txValid,
    output logic txReady,
    input wire logic [17:0] txPgn,
    input wire logic [2:0] txPrio,
    input wire logic [63:0] txData,
    output logic got,
    output logic [17:0] gotPgn,
    output logic [2:0] gotPrio,
    output logic [63:0] gotData
);
    // ready follows the stall control, which only moves just after an edge
    assign txReady = !stall;
    // capture each accepted frame and flag it for one cycle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            got <= 1'b0;
            gotPgn <= 18'h00000;
            gotPrio <= 3'h0;
            gotData <= 64'h0;
        end
        else
        begin
            got <= txValid && txReady;
            if (txValid && txReady)
            begin
                gotPgn <= txPgn;
                gotPrio <= txPrio;
                gotData <= txData;
            end
        end
    end
endmodule // jarf_tx_sink

// file: sim/jarf_framer_tb.sv
`timescale 1ns/1ps
module jarf_framer_tb;
    import jarf_pkg::*;
    localparam int PER = 50;
    localparam int DRV = 1;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic slopeEnable = 1'b0, rateEnable = 1'b0, reqValid = 1'b0, stall = 1'b0;
    logic compOn = 1'b0, pitchCompErr = 1'b0, rollCompErr = 1'b0;
    logic [17:0] reqPgn = '0;
    logic signed [23:0] pitchAngle = 24'h008000, rollAngle = 24'hFF0000;
    logic [1:0] pitchQual = '0, rollQual = '0;
    logic [1:0] pitchRateQual = '0, rollRateQual = '0, yawRateQual = '0;
    logic [7:0] angleLatency = '0, rateLatency = '0;
    logic signed [15:0] pitchRate = 16'h0100, rollRate = 16'hFE00, yawRate = 16'h1234;
    logic signed [15:0] vehPitch = 16'h0C80, vehRoll = '0;
    logic txValid, txReady, got;
    logic [17:0] txPgn, gotPgn;
    logic [2:0] txPrio, gotPrio;
    logic [63:0] txData, gotData, exp;
    int fail_count = 0;
    int total_checks = 0;

    // free-running system clock
    always #50 clk_sys = ~clk_sys;

    jarf_framer #(.PERIOD_CYC(PER)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .slopeEnable(slopeEnable), .rateEnable(rateEnable), .reqValid(reqValid),
        .reqPgn(reqPgn), .pitchAngle(pitchAngle), .rollAngle(rollAngle), .compOn(compOn),
        .pitchCompErr(pitchCompErr), .rollCompErr(rollCompErr), .pitchQual(pitchQual),
        .rollQual(rollQual), .angleLatency(angleLatency), .pitchRate(pitchRate),
        .rollRate(rollRate), .yawRate(yawRate), .pitchRateQual(pitchRateQual),
        .rollRateQual(rollRateQual), .yawRateQual(yawRateQual), .rateLatency(rateLatency),
        .vehPitch(vehPitch), .vehRoll(vehRoll), .txValid(txValid), .txReady(txReady),
        .txPgn(txPgn), .txPrio(txPrio), .txData(txData));

    jarf_tx_sink i_sink (.clk_sys(clk_sys), .rst_n(rst_n), .stall(stall),
        .txValid(txValid), .txReady(txReady), .txPgn(txPgn), .txPrio(txPrio),
        .txData(txData), .got(got), .gotPgn(gotPgn), .gotPrio(gotPrio), .gotData(gotData));

    // closing report and verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic chkFrame(input logic [17:0] p, input logic [2:0] pr, input logic [63:0] d);
        chk({46'h0, gotPgn}, {46'h0, p}, "group");
        chk({61'h0, gotPrio}, {61'h0, pr}, "priority");
        chk(gotData, d, "payload");
    endtask

    task automatic step(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            #DRV;
        end
    endtask

    // waits for the sink to take a frame; n is the cycle count spent
    task automatic waitFrame(output int n);
        n = 0;
        do
        begin
            step(1);
            n++;
            if (n > 300)
            begin
                fail_count++;
                $display("ERROR %0t no frame arrived", $time);
                summarize();
            end
        end
        while (got !== 1'b1);
    endtask

    // request pulse; the caller lowers reqValid when the burst ends
    task automatic req(input logic [17:0] p);
        reqPgn = p;
        reqValid = 1'b1;
        step(1);
    endtask

    // periodic rate frames, every quality code, repeat spacing
    task automatic testRate();
        int n;
        for (int i = 0; i < 4; i++)
        begin
            pitchRateQual = 2'(i);
            rollRateQual = 2'(i + 1);
            yawRateQual = 2'(i + 2);
            rateLatency = 8'hFC + 8'(i);
            yawRate = (i == 3) ? 16'sh0000 : 16'sh1234;
            rateEnable = 1'b1;
            waitFrame(n);
            exp = {rateLatency, 2'h3, yawRateQual, rollRateQual, pitchRateQual,
                16'h7D00 + yawRate, 16'h7D00 + rollRate, 16'h7D00 + pitchRate};
            chkFrame(18'd61482, 3'h3, exp);
            if (i > 1)
                chk(64'(n), 64'(PER), "rate spacing");
        end
        rateEnable = 1'b0;
        step(5);
    endtask

    // periodic slope frames, compensation codes, latency limit
    task automatic testSlope();
        logic [7:0] lin [4] = '{8'hFF, 8'hFA, 8'h00, 8'h7B};
        logic [7:0] lex [4] = '{8'hFA, 8'hFA, 8'h00, 8'h7B};
        logic [1:0] pc [4] = '{2'h0, 2'h1, 2'h0, 2'h2};
        logic [1:0] rc [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
        int n;
        for (int i = 0; i < 4; i++)
        begin
            compOn = (i == 0 || i == 2);
            pitchCompErr = (i == 3);
            rollCompErr = (i == 2);
            pitchQual = 2'(3 - i);
            rollQual = 2'(i);
            angleLatency = lin[i];
            pitchAngle = (i == 3) ? 24'sh000000 : 24'sh008000;
            slopeEnable = 1'b1;
            waitFrame(n);
            exp = {lex[i], rollQual, rc[i], pitchQual, pc[i],
                24'h7D0000 + rollAngle, 24'h7D0000 + pitchAngle};
            chkFrame(18'd61481, 3'h3, exp);
            if (i > 1)
                chk(64'(n), 64'(PER), "slope spacing");
        end
        slopeEnable = 1'b0;
        step(5);
    endtask

    // on-request frames, roll limit, nothing periodic, foreign groups ignored
    task automatic testRequest();
        logic [15:0] rin [2] = '{16'h3200, 16'hF600};
        logic [15:0] rex [2] = '{16'h9100, 16'h5A00};
        logic [15:0] pin [2] = '{16'h0C80, 16'h0000};
        logic [15:0] pex [2] = '{16'h7080, 16'h6400};
        int n;
        int cnt;
        for (int i = 0; i < 2; i++)
        begin
            vehRoll = rin[i];
            vehPitch = pin[i];
            req(18'd65256);
            reqValid = 1'b0;
            waitFrame(n);
            chkFrame(18'd65256, 3'h6, {16'hFFFF, pex[i], 32'hFFFFFFFF});
            req(18'd64905);
            reqValid = 1'b0;
            waitFrame(n);
            chkFrame(18'd64905, 3'h6, {48'hFFFFFFFFFFFF, rex[i]});
        end
        req(18'd61482);
        reqValid = 1'b0;
        cnt = 0;
        for (int i = 0; i < 3 * PER; i++)
        begin
            step(1);
            cnt += (got === 1'b1);
        end
        chk(64'(cnt), 64'h0, "unrequested frame");
    endtask

    // receiver stalls with more frames than buffer entries; none lost, order kept
    task automatic testStall();
        logic [17:0] ord [3] = '{18'd65256, 18'd64905, 18'd65256};
        int n;
        stall = 1'b1;
        req(18'd65256);
        req(18'd64905);
        req(18'd65256);
        reqValid = 1'b0;
        step(10);
        chk({63'h0, txValid}, 64'h1, "held valid");
        chk({46'h0, txPgn}, {46'h0, 18'd65256}, "held group");
        stall = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            waitFrame(n);
            chk({46'h0, gotPgn}, {46'h0, ord[i]}, "stall order");
            if (i == 1)
                chk(64'(n), 64'h1, "buffered back to back");
        end
    endtask

    // main sequence
    initial
    begin
        repeat (8) @(posedge clk_sys);
        #DRV;
        rst_n = 1'b1;
        chk({63'h0, txValid}, 64'h0, "idle after reset");
        testRate();
        testSlope();
        testRequest();
        testStall();
        summarize();
    end
endmodule // jarf_framer_tb
